// File: gpio_port_pkg.sv
// Constants for the eight-pin configurable I/O port: register map,
// field layouts, drive-mode and interrupt-type codes, reset values.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
//
// Functional notes
// - Open-drain modes float for one data value and drive strongly for the other.
// - Strong mode drives both data values; input use is not intended.
// - Mode 7 always drives through a resistor: up for high, down for low.
// - Every configuration register exists in port form; the pin-form fields use one bit per pin.
// - A per-pin register holds eight common bits; both forms share state.
// - Bidirectional pins switch between high-Z digital and their mode by aux output enable.
// - The aux control bus carries sixteen output enables, each routable to pins.
// - Per-pin slew select applies only in strong and open-drain modes.
// - All eight pins feed one port interrupt unit with one request.
// - Interrupt type per pin: rising, falling, both edges, or disabled.
// - A configured edge sets the pin's status bit and raises the request.
// - Edge detection and request logic keep running in all low-power modes.
// - No level-sensitive triggering is offered by the interrupt unit.
// - Input threshold per port: CMOS by default, LVTTL optional.
// - Per-pin input buffer disable in any mode removes the digital input.
// - Each special pin selects supply high level or regulated high output.
// - Special pins pair on one reference with four selectable thresholds.
// - Special pins offer an input hysteresis enable.
// - During reset every pin is held in high-Z analog mode.
// - At reset release the stored reset configuration loads: high-Z, pull-up or pull-down.
// - Pins keep their drive state in low-power modes until changed or reset.
// - Drive-mode codes 0..7 as listed: analog, digital, PU, PD, ODL, ODH, strong, PUPD.
// - Pin state readback and output latch are separate; reads never alter the latch.

`default_nettype none

package gpio_port_pkg;

   localparam int NUM_PINS = 8;
   localparam int ADDR_W   = 8;

   // ------------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] OFS_OUTPUT_LATCH = 8'h00;
   localparam logic [7:0] OFS_PIN_STATE    = 8'h04;
   localparam logic [7:0] OFS_DRIVE_MODE0  = 8'h08;
   localparam logic [7:0] OFS_DRIVE_MODE1  = 8'h0c;
   localparam logic [7:0] OFS_DRIVE_MODE2  = 8'h10;
   localparam logic [7:0] OFS_SLEW         = 8'h14;
   localparam logic [7:0] OFS_BUF_DISABLE  = 8'h18;
   localparam logic [7:0] OFS_BIDIR_EN     = 8'h1c;
   localparam logic [7:0] OFS_OE_SELECT    = 8'h20;
   localparam logic [7:0] OFS_INT_TYPE     = 8'h24;
   localparam logic [7:0] OFS_INT_STATUS   = 8'h28;
   localparam logic [7:0] OFS_PORT_CFG     = 8'h2c;
   localparam logic [7:0] OFS_RESET_CFG    = 8'h30;
   localparam logic [7:0] OFS_SPECIAL_CFG  = 8'h34;
   localparam logic [2:0] PIN_FORM_REGION  = 3'h2;   // address[7:5], pins at 0x40 + 4*pin

   // ------------------------------------------------------------------
   // Pin-form field positions
   // ------------------------------------------------------------------
   localparam int PF_LATCH  = 0;
   localparam int PF_STATE  = 1;
   localparam int PF_DM_LO  = 2;
   localparam int PF_SLEW   = 5;
   localparam int PF_BIDIR  = 6;
   localparam int PF_BUFDIS = 7;

   // Special-pin configuration fields
   localparam int SC_VREG_LO   = 0;
   localparam int SC_HYST_LO   = 8;
   localparam int SC_THRESH_LO = 16;

   // ------------------------------------------------------------------
   // Codes
   // ------------------------------------------------------------------
   localparam logic [2:0] DM_HIZ_ANALOG  = 3'h0;
   localparam logic [2:0] DM_HIZ_DIGITAL = 3'h1;
   localparam logic [2:0] DM_PULL_UP     = 3'h2;
   localparam logic [2:0] DM_PULL_DOWN   = 3'h3;
   localparam logic [2:0] DM_OD_LOW      = 3'h4;
   localparam logic [2:0] DM_OD_HIGH     = 3'h5;
   localparam logic [2:0] DM_STRONG      = 3'h6;
   localparam logic [2:0] DM_PULL_UPDOWN = 3'h7;

   localparam logic [1:0] IT_DISABLED = 2'h0;
   localparam logic [1:0] IT_RISING   = 2'h1;
   localparam logic [1:0] IT_FALLING  = 2'h2;
   localparam logic [1:0] IT_BOTH     = 2'h3;

   localparam logic [1:0] RC_HIZ       = 2'h0;
   localparam logic [1:0] RC_PULL_UP   = 2'h1;
   localparam logic [1:0] RC_PULL_DOWN = 2'h2;

   localparam logic [31:0] RST_ZERO = 32'h0000_0000;

endpackage : gpio_port_pkg

`default_nettype wire

// File: configurable_io_port.sv
// Eight-pin configurable I/O port: drive modes, bidirectional switching,
// edge interrupts, input buffer and special-pin settings, Avalon-MM slave.
// Assumes aux enables are synchronous inputs; pin inputs pass a two-flop synchroniser; the pad
// resolves pin level from out, output-enable and pull controls.
//
// The Avalon-MM register port and the placing of the registers were decided locally.

`timescale 1ns/10ps
`default_nettype none

module configurable_io_port (
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   // Avalon-MM slave
   input  wire logic [7:0]  address_i,
   input  wire logic        read_i,
   input  wire logic        write_i,
   input  wire logic [31:0] writedata_i,
   input  wire logic [3:0]  byteenable_i,
   output logic             waitrequest_o,
   output logic [31:0]      readdata_o,
   // Stored reset configuration from nonvolatile storage
   input  wire logic [1:0]  nv_reset_cfg_i,
   // Auxiliary output-enable bus
   input  wire logic [15:0] aux_oe_i,
   // Pads
   input  wire logic [7:0]  pin_i,
   output logic [7:0]       pin_o,
   output logic [7:0]       pin_oe_b_o,
   output logic [7:0]       pin_pull_up_o,
   output logic [7:0]       pin_pull_down_o,
   output logic [7:0]       pin_ibuf_en_o,
   output logic [7:0]       pin_slow_o,
   output logic             lvttl_o,
   output logic [7:0]       vreg_sel_o,
   output logic [7:0]       hyst_en_o,
   output logic [7:0]       pair_thresh_o,
   // Port interrupt request
   output logic             irq_o
);

   typedef enum logic [1:0] {ST_RESET, ST_LOAD, ST_RUN} port_state_t;

   port_state_t  st_q;
   logic         ack_q;
   logic [31:0]  readdata_q;
   logic [7:0]   latch_q, latch_d;
   logic [7:0]   dm0_q, dm0_d;
   logic [7:0]   dm1_q, dm1_d;
   logic [7:0]   dm2_q, dm2_d;
   logic [7:0]   slew_q, slew_d;
   logic [7:0]   bidir_q, bidir_d;
   logic [7:0]   bufdis_q, bufdis_d;
   logic [31:0]  oesel_q;
   logic [15:0]  inttype_q;
   logic [7:0]   status_q;
   logic         lvttl_q;
   logic [1:0]   rstcfg_q;
   logic [23:0]  special_q;
   logic [7:0]   sync1_q, sync2_q, prev_q;
   logic [7:0]   gated_in;
   logic [7:0]   ibuf_en;
   logic [7:0]   edge_evt;
   logic [7:0]   out_q, oe_b_q, pu_q, pd_q, slow_q;

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  be);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      return (old_v & ~m) | (new_v & m);
   endfunction : merge

   // ------------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------------
   // One wait cycle per access in ST_RUN: the answer comes one edge later,
   // which keeps read data registered and read-clear side effects simple.
   wire        req        = read_i | write_i;
   wire        run        = (st_q == ST_RUN);
   wire        done       = req & ack_q;
   wire        wr_done    = write_i & done;
   wire        rd_done    = read_i & done;
   wire        sel_latch  = (address_i == gpio_port_pkg::OFS_OUTPUT_LATCH);
   wire        sel_state  = (address_i == gpio_port_pkg::OFS_PIN_STATE);
   wire        sel_dm0    = (address_i == gpio_port_pkg::OFS_DRIVE_MODE0);
   wire        sel_dm1    = (address_i == gpio_port_pkg::OFS_DRIVE_MODE1);
   wire        sel_dm2    = (address_i == gpio_port_pkg::OFS_DRIVE_MODE2);
   wire        sel_slew   = (address_i == gpio_port_pkg::OFS_SLEW);
   wire        sel_bufdis = (address_i == gpio_port_pkg::OFS_BUF_DISABLE);
   wire        sel_bidir  = (address_i == gpio_port_pkg::OFS_BIDIR_EN);
   wire        sel_oesel  = (address_i == gpio_port_pkg::OFS_OE_SELECT);
   wire        sel_itype  = (address_i == gpio_port_pkg::OFS_INT_TYPE);
   wire        sel_status = (address_i == gpio_port_pkg::OFS_INT_STATUS);
   wire        sel_pcfg   = (address_i == gpio_port_pkg::OFS_PORT_CFG);
   wire        sel_rcfg   = (address_i == gpio_port_pkg::OFS_RESET_CFG);
   wire        sel_spec   = (address_i == gpio_port_pkg::OFS_SPECIAL_CFG);
   wire        sel_pin    = (address_i[7:5] == gpio_port_pkg::PIN_FORM_REGION) & (address_i[1:0] == 2'h0);
   wire [2:0]  pidx       = address_i[4:2];
   wire        wr_lo      = wr_done & byteenable_i[0];
   wire [31:0] wd         = writedata_i;

   // Byte-lane merges for the wide registers, cut back to register width
   wire [31:0] itype_merged = merge({16'h0000, inttype_q}, wd, byteenable_i);
   wire [31:0] spec_merged  = merge({8'h00, special_q}, wd, byteenable_i);

   assign waitrequest_o = req & ~ack_q;
   assign readdata_o    = readdata_q;

   // Pin-form view of one pin
   wire [7:0] pin_form_rd = {bufdis_q[pidx], bidir_q[pidx], slew_q[pidx], dm2_q[pidx],
                             dm1_q[pidx], dm0_q[pidx], gated_in[pidx], latch_q[pidx]};

   // Read mux; unmapped addresses read as zero
   wire [31:0] rd_word =
      sel_latch  ? {24'h000000, latch_q}                :
      sel_state  ? {24'h000000, gated_in}               :
      sel_dm0    ? {24'h000000, dm0_q}                  :
      sel_dm1    ? {24'h000000, dm1_q}                  :
      sel_dm2    ? {24'h000000, dm2_q}                  :
      sel_slew   ? {24'h000000, slew_q}                 :
      sel_bufdis ? {24'h000000, bufdis_q}               :
      sel_bidir  ? {24'h000000, bidir_q}                :
      sel_oesel  ? oesel_q                              :
      sel_itype  ? {16'h0000, inttype_q}                :
      sel_status ? {24'h000000, status_q}               :
      sel_pcfg   ? {31'h00000000, lvttl_q}              :
      sel_rcfg   ? {30'h00000000, rstcfg_q}             :
      sel_spec   ? {8'h00, special_q}                   :
      sel_pin    ? {24'h000000, pin_form_rd}            :
                   32'h0000_0000;

   // ------------------------------------------------------------------
   // Sequencing and bus handshake
   // ------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         st_q       <= ST_RESET;
         ack_q      <= 1'b0;
         readdata_q <= gpio_port_pkg::RST_ZERO;
      end else begin
         case (st_q)
            ST_RESET: st_q <= ST_LOAD;
            ST_LOAD:  st_q <= ST_RUN;
            ST_RUN:   st_q <= ST_RUN;
            default:  st_q <= ST_RESET;
         endcase
         ack_q <= req & ~ack_q & run;
         if (read_i & ~ack_q)
            readdata_q <= rd_word;
      end
   end

   // ------------------------------------------------------------------
   // Port-form and pin-form writes share one set of bit planes
   // ------------------------------------------------------------------
   wire load_cfg = (st_q == ST_LOAD);
   wire pin_wr   = wr_lo & sel_pin;

   always_comb begin
      latch_d  = latch_q;
      dm0_d    = dm0_q;
      dm1_d    = dm1_q;
      dm2_d    = dm2_q;
      slew_d   = slew_q;
      bidir_d  = bidir_q;
      bufdis_d = bufdis_q;
      if (load_cfg) begin
         // Stored reset data picks pull-up or pull-down for the whole port
         if (nv_reset_cfg_i == gpio_port_pkg::RC_PULL_UP) begin
            latch_d = 8'hff;
            {dm2_d, dm1_d, dm0_d} = {8'h00, 8'hff, 8'h00};
         end else if (nv_reset_cfg_i == gpio_port_pkg::RC_PULL_DOWN) begin
            latch_d = 8'h00;
            {dm2_d, dm1_d, dm0_d} = {8'h00, 8'hff, 8'hff};
         end
      end else if (pin_wr) begin
         latch_d[pidx]  = wd[gpio_port_pkg::PF_LATCH];
         dm0_d[pidx]    = wd[gpio_port_pkg::PF_DM_LO];
         dm1_d[pidx]    = wd[gpio_port_pkg::PF_DM_LO + 1];
         dm2_d[pidx]    = wd[gpio_port_pkg::PF_DM_LO + 2];
         slew_d[pidx]   = wd[gpio_port_pkg::PF_SLEW];
         bidir_d[pidx]  = wd[gpio_port_pkg::PF_BIDIR];
         bufdis_d[pidx] = wd[gpio_port_pkg::PF_BUFDIS];
      end else if (wr_lo) begin
         if (sel_latch)  latch_d  = wd[7:0];
         if (sel_dm0)    dm0_d    = wd[7:0];
         if (sel_dm1)    dm1_d    = wd[7:0];
         if (sel_dm2)    dm2_d    = wd[7:0];
         if (sel_slew)   slew_d   = wd[7:0];
         if (sel_bidir)  bidir_d  = wd[7:0];
         if (sel_bufdis) bufdis_d = wd[7:0];
      end
   end

   // Read of the status register clears it; a new edge in the same
   // cycle survives, but one from the wait cycle before is cleared unread.
   wire [7:0] status_clr = (rd_done & sel_status) ? 8'hff : 8'h00;
   wire [7:0] status_d   = (status_q & ~status_clr) | edge_evt;

   // ------------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------------
   // No clock gating anywhere: interrupt logic and held drive state keep
   // working through any low-power mode as long as clk_i runs.
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         latch_q   <= 8'h00;
         dm0_q     <= 8'h00;
         dm1_q     <= 8'h00;
         dm2_q     <= 8'h00;
         slew_q    <= 8'h00;
         bidir_q   <= 8'h00;
         bufdis_q  <= 8'h00;
         oesel_q   <= gpio_port_pkg::RST_ZERO;
         inttype_q <= 16'h0000;
         status_q  <= 8'h00;
         lvttl_q   <= 1'b0;
         rstcfg_q  <= gpio_port_pkg::RC_HIZ;
         special_q <= 24'h000000;
      end else begin
         latch_q   <= latch_d;
         dm0_q     <= dm0_d;
         dm1_q     <= dm1_d;
         dm2_q     <= dm2_d;
         slew_q    <= slew_d;
         bidir_q   <= bidir_d;
         bufdis_q  <= bufdis_d;
         status_q  <= status_d;
         if (load_cfg)
            rstcfg_q <= nv_reset_cfg_i;
         if (wr_done & sel_oesel)
            oesel_q <= merge(oesel_q, wd, byteenable_i);
         if (wr_done & sel_itype)
            inttype_q <= itype_merged[15:0];
         if (wr_lo & sel_pcfg)
            lvttl_q <= wd[0];
         if (wr_done & sel_spec)
            special_q <= spec_merged[23:0];
      end
   end

   // ------------------------------------------------------------------
   // Per-pin drive, input and edge logic
   // ------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < gpio_port_pkg::NUM_PINS; g++) begin : g_pin
         wire [2:0] mode     = {dm2_q[g], dm1_q[g], dm0_q[g]};
         wire [3:0] oe_line  = oesel_q[4*g +: 4];
         wire       aux_en   = aux_oe_i[oe_line];
         // Bidirectional pin falls back to high-Z digital while its enable is low
         wire [2:0] eff_mode = (bidir_q[g] & ~aux_en) ? gpio_port_pkg::DM_HIZ_DIGITAL : mode;
         wire       dat      = latch_q[g];
         logic      drv, pu, pd, slow_ok;
         wire [1:0] itype    = inttype_q[2*g +: 2];

         always_comb begin
            drv     = 1'b0;
            pu      = 1'b0;
            pd      = 1'b0;
            slow_ok = 1'b0;
            case (eff_mode)
               gpio_port_pkg::DM_PULL_UP: begin
                  drv = ~dat;
                  pu  = dat;
               end
               gpio_port_pkg::DM_PULL_DOWN: begin
                  drv = dat;
                  pd  = ~dat;
               end
               gpio_port_pkg::DM_OD_LOW: begin
                  drv     = ~dat;
                  slow_ok = 1'b1;
               end
               gpio_port_pkg::DM_OD_HIGH: begin
                  drv     = dat;
                  slow_ok = 1'b1;
               end
               gpio_port_pkg::DM_STRONG: begin
                  drv     = 1'b1;
                  slow_ok = 1'b1;
               end
               gpio_port_pkg::DM_PULL_UPDOWN: begin
                  pu = dat;
                  pd = ~dat;
               end
               default: begin
                  drv = 1'b0;
               end
            endcase
         end

         // Analog mode and a disabled buffer both cut the digital input
         assign ibuf_en[g]  = ~bufdis_q[g] & (eff_mode != gpio_port_pkg::DM_HIZ_ANALOG);
         assign gated_in[g] = sync2_q[g] & ibuf_en[g];
         // Edges only; a held level never retriggers
         assign edge_evt[g] = ((itype == gpio_port_pkg::IT_RISING  |  itype == gpio_port_pkg::IT_BOTH)
                                 & gated_in[g] & ~prev_q[g])
                            | ((itype == gpio_port_pkg::IT_FALLING |  itype == gpio_port_pkg::IT_BOTH)
                                 & ~gated_in[g] & prev_q[g]);

         always_ff @(posedge clk_i) begin
            if (!rst_b_i) begin
               out_q[g]  <= 1'b0;
               oe_b_q[g] <= 1'b1;
               pu_q[g]   <= 1'b0;
               pd_q[g]   <= 1'b0;
               slow_q[g] <= 1'b0;
               sync1_q[g] <= 1'b0;
               sync2_q[g] <= 1'b0;
               prev_q[g]  <= 1'b0;
            end else begin
               out_q[g]   <= dat;
               oe_b_q[g]  <= ~drv;
               pu_q[g]    <= pu;
               pd_q[g]    <= pd;
               slow_q[g]  <= slew_q[g] & slow_ok;
               sync1_q[g] <= pin_i[g];
               sync2_q[g] <= sync1_q[g];
               prev_q[g]  <= gated_in[g];
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign pin_o           = out_q;
   assign pin_oe_b_o      = oe_b_q;
   assign pin_pull_up_o   = pu_q;
   assign pin_pull_down_o = pd_q;
   assign pin_ibuf_en_o   = ibuf_en;
   assign pin_slow_o      = slow_q;
   assign lvttl_o         = lvttl_q;
   assign vreg_sel_o      = special_q[gpio_port_pkg::SC_VREG_LO +: 8];
   assign hyst_en_o       = special_q[gpio_port_pkg::SC_HYST_LO +: 8];
   assign pair_thresh_o   = special_q[gpio_port_pkg::SC_THRESH_LO +: 8];
   assign irq_o           = |status_q;

endmodule : configurable_io_port

`default_nettype wire

// File: configurable_io_port_asserts.sv
// Port-level checks on configurable_io_port, attached by bind.
// Assumes the bus master idles at least one cycle between accesses.
`timescale 1ns/10ps
`default_nettype none
module configurable_io_port_asserts (
   input wire logic       clk_i,
   input wire logic       rst_b_i,
   input wire logic [7:0] address_i,
   input wire logic       read_i,
   input wire logic       write_i,
   input wire logic       waitrequest_o,
   input wire logic [7:0] pin_i,
   input wire logic [7:0] pin_oe_b_o,
   input wire logic [7:0] pin_pull_up_o,
   input wire logic [7:0] pin_pull_down_o,
   input wire logic [7:0] pin_slow_o,
   input wire logic       irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence s_req_start; $rose(read_i || write_i); endsequence
   sequence s_req_done; ##[1:8] !waitrequest_o; endsequence
   a_wait_first_cycle: assert property (s_req_start |-> waitrequest_o)
      else $error("access without wait cycle");
   a_wait_bounded: assert property (s_req_start |-> s_req_done)
      else $error("access not answered");
   a_idle_no_wait: assert property (!read_i && !write_i |-> !waitrequest_o)
      else $error("wait raised while idle");
   a_reset_hiz_analog: assert property (disable iff (1'b0)
      !rst_b_i |=> &pin_oe_b_o && !(pin_pull_up_o | pin_pull_down_o)) else $error("pin driven in reset");
   a_drive_no_pull: assert property (!(~pin_oe_b_o & (pin_pull_up_o | pin_pull_down_o)))
      else $error("pull on strongly driven pin");
   a_slow_not_resistive: assert property (!(pin_slow_o & (pin_pull_up_o | pin_pull_down_o)))
      else $error("slow slew in resistive mode");
   a_irq_from_edge: assert property ($rose(irq_o) |-> $past(pin_i, 2) != $past(pin_i, 3) ||
      $past(pin_i, 3) != $past(pin_i, 4) || $past(pin_i, 4) != $past(pin_i, 5)) else $error("request without edge");
   a_irq_clear_read: assert property ($fell(irq_o) |->
      $past(read_i && !waitrequest_o && address_i == gpio_port_pkg::OFS_INT_STATUS)) else $error("status lost");
endmodule : configurable_io_port_asserts
bind configurable_io_port configurable_io_port_asserts configurable_io_port_asserts_inst (.clk_i, .rst_b_i,
   .address_i, .read_i, .write_i, .waitrequest_o, .pin_i, .pin_oe_b_o, .pin_pull_up_o, .pin_pull_down_o,
   .pin_slow_o, .irq_o);
`default_nettype wire

// File: pad_model.sv
// Pads plus external circuitry for the eight port pins.
// Assumes an outside driver beats a pull resistor but never a strong driver.
`timescale 1ns/10ps
`default_nettype none
module pad_model (
   input  wire logic       clk_i,
   input  wire logic [7:0] drive_i,
   input  wire logic [7:0] oe_b_i,
   input  wire logic [7:0] pull_up_i,
   input  wire logic [7:0] pull_down_i,
   input  wire logic [7:0] ext_en_i,
   input  wire logic [7:0] ext_val_i,
   output wire logic [7:0] level_o
);
   logic [7:0] float_q = 8'h5a;
   wire  [7:0] res_w = (pull_up_i & pull_down_i & drive_i) | (pull_up_i & ~pull_down_i);
   wire  [7:0] idle_w = ~pull_up_i & ~pull_down_i;
   // A floating pad toggles so that it never reads as a settled value
   always @(posedge clk_i) float_q <= ~float_q;
   assign level_o = (~oe_b_i & drive_i) | (oe_b_i & ((ext_en_i & ext_val_i) |
                    (~ext_en_i & (res_w | (idle_w & float_q)))));
endmodule : pad_model
`default_nettype wire

// File: configurable_io_port_tb_top.sv
// Self-checking bench: bus master, pad model and a read scoreboard.
// Assumes one wait cycle per access and a two-flop pin synchroniser.
`timescale 1ns/10ps
`default_nettype none
module configurable_io_port_tb_top;
   logic        clk_i = 1'b0, rst_b_i = 1'b0, read_i = 1'b0, write_i = 1'b0;
   logic [7:0]  address_i = 8'h00, ext_en = 8'h00, ext_val = 8'h00, a;
   logic [31:0] writedata_i = 32'h0, e;
   logic [1:0]  nv_reset_cfg_i = 2'h0;
   logic [15:0] aux_oe_i = 16'h0;
   logic [7:0]  pin_i, pin_o, pin_oe_b_o, pin_pull_up_o, pin_pull_down_o;
   logic [31:0] readdata_o;
   logic        waitrequest_o, irq_o, lvttl_o;
   logic [7:0]  pin_slow_o, vreg_sel_o, hyst_en_o, pair_thresh_o;
   logic [31:0] exp_q[$];
   int          mismatches = 0, samples_checked = 0;
   configurable_io_port configurable_io_port_inst (.clk_i, .rst_b_i, .address_i, .read_i, .write_i, .writedata_i,
      .byteenable_i(4'hf), .waitrequest_o, .readdata_o, .nv_reset_cfg_i, .aux_oe_i, .pin_i, .pin_o, .pin_oe_b_o,
      .pin_pull_up_o, .pin_pull_down_o, .pin_ibuf_en_o(), .pin_slow_o, .lvttl_o, .vreg_sel_o, .hyst_en_o,
      .pair_thresh_o, .irq_o);
   pad_model pad_model_inst (.clk_i, .drive_i(pin_o), .oe_b_i(pin_oe_b_o), .pull_up_i(pin_pull_up_o),
      .pull_down_i(pin_pull_down_o), .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(pin_i));
   initial forever #2 clk_i = ~clk_i;
   task automatic end_sim;
      if (mismatches == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_sim
   task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int n = 0;
      {address_i, writedata_i, read_i, write_i} <= {ad, d, !w, w};
      do @(posedge clk_i); while (waitrequest_o !== 1'b0 && ++n < 40);
      {read_i, write_i} <= 2'b00;
      if (n >= 40) begin
         mismatches++;
         $display("unexpected at %0t: bus hang", $time);
         end_sim();
      end
      @(posedge clk_i);
   endtask : bus
   task automatic chk(input logic [31:0] got, input logic [31:0] x);
      samples_checked++;
      if (got !== x) begin
         mismatches++;
         $display("unexpected at %0t: output %h expected %h", $time, got, x);
      end
   endtask : chk
   task automatic rd(input logic [7:0] ad, input logic [31:0] x);
      exp_q.push_back(x);
      bus(1'b0, ad, 32'h0);
   endtask : rd
   task automatic mode(input logic [2:0] m);
      for (int b = 0; b < 3; b++) bus(1'b1, gpio_port_pkg::OFS_DRIVE_MODE0 + 8'(4 * b), {24'h0, {8{m[b]}}});
   endtask : mode
   always @(posedge clk_i) begin
      if (read_i && waitrequest_o === 1'b0) begin
         samples_checked++;
         if (exp_q.size() == 0 || readdata_o !== exp_q[0]) begin
            mismatches++;
            $display("unexpected at %0t: addr %h read %h", $time, address_i, readdata_o);
         end
         if (exp_q.size() > 0) void'(exp_q.pop_front());
      end
   end
   initial begin
      void'($urandom(32'hc40e1335));
      nv_reset_cfg_i <= 2'($urandom_range(2, 1));
      repeat (16) @(posedge clk_i);
      rst_b_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rd(gpio_port_pkg::OFS_DRIVE_MODE0, {24'h0, {8{nv_reset_cfg_i[1]}}});
      rd(gpio_port_pkg::OFS_PIN_STATE, {24'h0, {8{nv_reset_cfg_i[0]}}});
      // Index bits 3:1 pick the mode, bit 0 the data; floating pads (no driver, no pull) get outside data
      for (int m = 0; m < 16; m++) begin
         e = $urandom;
         a = (m < 4 || m == 9 || m == 10) ? 8'hff : 8'h00;
         ext_en <= a;
         ext_val <= e[7:0];
         bus(1'b1, gpio_port_pkg::OFS_OUTPUT_LATCH, {24'h0, {8{m[0]}}});
         mode(m[3:1]);
         repeat (4) @(posedge clk_i);
         rd(gpio_port_pkg::OFS_PIN_STATE, m < 2 ? 32'h0 : {24'h0, (a & e[7:0]) | (~a & {8{m[0]}})});
      end
      bus(1'b1, 8'h54, 32'h39);
      bus(1'b1, gpio_port_pkg::OFS_BUF_DISABLE, 32'h0f);
      repeat (4) @(posedge clk_i);
      chk({24'h0, pin_slow_o}, 32'h20);
      rd(gpio_port_pkg::OFS_DRIVE_MODE0, 32'hdf);
      rd(8'h54, 32'h3b);
      rd(gpio_port_pkg::OFS_PIN_STATE, 32'hf0);
      bus(1'b1, gpio_port_pkg::OFS_BUF_DISABLE, 32'h0);
      mode(3'h6);
      bus(1'b1, gpio_port_pkg::OFS_OUTPUT_LATCH, 32'h0);
      bus(1'b1, gpio_port_pkg::OFS_BIDIR_EN, 32'hff);
      bus(1'b1, gpio_port_pkg::OFS_OE_SELECT, 32'h3d2e1f0c);
      e = $urandom;
      for (int g = 0; g < 8; g++) a[g] = e[4'(32'h3d2e1f0c >> (4 * g))];
      aux_oe_i <= e[15:0];
      ext_en <= ~a;
      ext_val <= 8'hff;
      repeat (4) @(posedge clk_i);
      rd(gpio_port_pkg::OFS_PIN_STATE, {24'h0, ~a});
      ext_en <= 8'hff;
      ext_val <= 8'h00;
      mode(3'h1);
      for (int t = 0; t < 4; t++) begin
         bus(1'b1, gpio_port_pkg::OFS_INT_TYPE, {16'h0, {8{2'(t)}}});
         ext_val <= 8'hff;
         repeat (6) @(posedge clk_i);
         chk({31'h0, irq_o}, {31'h0, t[0]});
         rd(gpio_port_pkg::OFS_INT_STATUS, {24'h0, {8{t[0]}}});
         ext_val <= 8'h00;
         repeat (6) @(posedge clk_i);
         chk({31'h0, irq_o}, {31'h0, t[1]});
         rd(gpio_port_pkg::OFS_INT_STATUS, {24'h0, {8{t[1]}}});
      end
      e = $urandom & 32'h00ffffff;
      bus(1'b1, gpio_port_pkg::OFS_SPECIAL_CFG, e);
      rd(gpio_port_pkg::OFS_SPECIAL_CFG, e);
      chk({8'h0, pair_thresh_o, hyst_en_o, vreg_sel_o}, e);
      bus(1'b1, gpio_port_pkg::OFS_PORT_CFG, 32'h1);
      chk({31'h0, lvttl_o}, 32'h1);
      rd(gpio_port_pkg::OFS_PORT_CFG, 32'h1);
      rd(8'h3c, 32'h0);
      end_sim();
   end
endmodule : configurable_io_port_tb_top
`default_nettype wire
